/* core/fcdp_pkg.sv */
package fcdp_pkg;
  // load mode codes on mode_select[2:0]
  localparam logic [2:0] FCDP_MODE_MASTER_SERIAL = 3'h0;
  localparam logic [2:0] FCDP_MODE_SLAVE_PARALLEL = 3'h1;
  localparam logic [2:0] FCDP_MODE_RESERVED = 3'h2;
  localparam logic [2:0] FCDP_MODE_SYNC_PERIPH = 3'h3;
  localparam logic [2:0] FCDP_MODE_MASTER_UP = 3'h4;
  localparam logic [2:0] FCDP_MODE_ASYNC_PERIPH = 3'h5;
  localparam logic [2:0] FCDP_MODE_MASTER_DOWN = 3'h6;
  localparam logic [2:0] FCDP_MODE_SLAVE_SERIAL = 3'h7;
  // timing
  localparam int FCDP_CLK_MHZ = 100;
  localparam int FCDP_PROGRAM_REQUEST_N_PULSE_NS = 500;
  localparam int FCDP_PROGRAM_REQUEST_N_CYCLES = (FCDP_PROGRAM_REQUEST_N_PULSE_NS * FCDP_CLK_MHZ + 999) / 1000;
  localparam int FCDP_HALF_PERIOD_CYCLES = 4;
  localparam int FCDP_SYNC_FIRST_EDGE = 2;
  localparam int FCDP_BYTE_BITS = 8;
  localparam logic FCDP_OSC_SLOW = 1'b1;
  // user-side command
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fcdp_byte_t;
  // pins toward the device
  typedef struct packed {
    logic program_request_n;
    logic config_clock;
    logic config_clock_oe;
    logic select_low;
    logic select_high;
    logic write_strobe_n;
    logic read_strobe_n;
    logic [7:0] bus_out;
    logic [7:0] bus_oe;
    logic serial_out;
    logic [2:0] mode_select;
    logic osc_rate_select;
  } fcdp_pins_t;
endpackage

/* core/fcdp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module fcdp_sync import fcdp_pkg::*; #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s1_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;
  always_comb begin
    s1_next = s1_reg;
    q_next = q_reg;
    if (ce) begin
      s1_next = d;
      q_next = s1_reg;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      q_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      q_reg <= q_next;
    end
  end
  assign q = q_reg;
endmodule
`default_nettype wire

/* core/fcdp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fcdp_host import fcdp_pkg::*; #(
  parameter int HALF = FCDP_HALF_PERIOD_CYCLES,
  parameter int FLUSH_CLOCKS = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [2:0] mode,
  input wire logic program_req,
  input wire fcdp_byte_t byte_in,
  output logic byte_ready,
  input wire logic last_byte,
  output logic busy,
  output logic done,
  output logic error,
  output fcdp_pins_t pins,
  input wire logic init_status_n,
  input wire logic config_complete,
  input wire logic byte_accept,
  input wire logic [7:0] bus_in
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [3:0] sy;
  fcdp_sync #(.W(4)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d({init_status_n, config_complete, byte_accept, bus_in[7]}),
    .q(sy)
  );
  logic init_s, done_s, acc_s, d7_s;
  assign init_s = sy[3];
  assign done_s = sy[2];
  assign acc_s = sy[1];
  assign d7_s = sy[0];

  ////////////////////////////////////////////////////////////////////////////
  typedef enum {
    S_IDLE, S_PULSE, S_WAIT_INIT, S_GET, S_WR, S_POLL, S_CLK_LO, S_CLK_HI, S_FLUSH, S_WAIT_DONE
  } fcdp_state_t;

  fcdp_state_t st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic last_reg, last_next;
  logic first_reg, first_next;
  logic ready_reg, ready_next;
  logic done_reg, done_next;
  logic err_reg, err_next;
  fcdp_pins_t p_reg, p_next;

  logic is_ser, is_par_clk, is_async;
  assign is_ser = (p_reg.mode_select == FCDP_MODE_SLAVE_SERIAL);
  assign is_par_clk = (p_reg.mode_select == FCDP_MODE_SLAVE_PARALLEL) ||
                      (p_reg.mode_select == FCDP_MODE_SYNC_PERIPH);
  assign is_async = (p_reg.mode_select == FCDP_MODE_ASYNC_PERIPH);

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    last_next = last_reg;
    first_next = first_reg;
    ready_next = 1'b0;
    done_next = done_reg;
    err_next = err_reg;
    p_next = p_reg;
    case (st_reg)
      S_IDLE: begin
        p_next.config_clock_oe = 1'b0;
        p_next.bus_oe = 8'h00;
        if (program_req) begin
          p_next.mode_select = mode;
          // slow oscillator advised for master serial
          p_next.osc_rate_select = FCDP_OSC_SLOW;
          p_next.program_request_n = 1'b0;
          cnt_next = 16'h0000;
          done_next = 1'b0;
          err_next = 1'b0;
          st_next = S_PULSE;
        end
      end
      S_PULSE: begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == 16'(FCDP_PROGRAM_REQUEST_N_CYCLES - 1)) begin
          p_next.program_request_n = 1'b1;
          cnt_next = 16'h0000;
          st_next = S_WAIT_INIT;
        end
      end
      S_WAIT_INIT: begin
        // master modes clock themselves; the device drives config_clock
        if (init_s) begin
          first_next = 1'b1;
          p_next.config_clock = 1'b0;
          p_next.config_clock_oe = is_ser || is_par_clk;
          if (is_par_clk || is_ser || is_async) begin
            st_next = S_GET;
          end else begin
            st_next = S_WAIT_DONE;
          end
        end
      end
      S_GET: begin
        if (!init_s && !first_reg) begin
          err_next = 1'b1;
          st_next = S_IDLE;
        end else if (byte_in.valid) begin
          sh_next = byte_in.data;
          last_next = last_byte;
          bit_next = 4'h0;
          cnt_next = 16'h0000;
          if (is_async) begin
            p_next.select_low = 1'b0;
            p_next.select_high = 1'b1;
            p_next.read_strobe_n = 1'b1;
            p_next.bus_out = byte_in.data;
            p_next.bus_oe = 8'hFF;
            p_next.write_strobe_n = 1'b0;
            st_next = S_WR;
          end else begin
            if (p_reg.mode_select == FCDP_MODE_SLAVE_PARALLEL) begin
              p_next.select_low = 1'b0;
              p_next.select_high = 1'b1;
              p_next.write_strobe_n = 1'b0;
            end
            p_next.bus_out = byte_in.data;
            p_next.bus_oe = is_par_clk ? 8'hFF : 8'h00;
            p_next.serial_out = byte_in.data[0];
            // this cycle already counts toward the low half period
            cnt_next = 16'h0001;
            st_next = S_CLK_LO;
          end
        end
      end
      S_WR: begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == 16'(HALF - 1)) begin
          p_next.write_strobe_n = 1'b1;
          p_next.select_low = 1'b1;
          p_next.select_high = 1'b0;
          p_next.bus_oe = 8'h00;
          cnt_next = 16'h0000;
          ready_next = 1'b1;
          st_next = S_POLL;
        end
      end
      S_POLL: begin
        // byte_accept needs time to fall after the write, so wait before polling
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg >= 16'h0004 && acc_s) begin
          cnt_next = 16'h0000;
          st_next = last_reg ? S_WAIT_DONE : S_GET;
        end
      end
      S_CLK_LO: begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == 16'(HALF - 1)) begin
          cnt_next = 16'h0000;
          p_next.config_clock = 1'b1;
          st_next = S_CLK_HI;
        end
      end
      S_CLK_HI: begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == 16'(HALF - 1)) begin
          cnt_next = 16'h0000;
          p_next.config_clock = 1'b0;
          bit_next = bit_reg + 4'h1;
          sh_next = {1'b0, sh_reg[7:1]};
          p_next.serial_out = sh_reg[1];
          if (p_reg.mode_select == FCDP_MODE_SLAVE_PARALLEL) begin
            first_next = 1'b0;
            ready_next = 1'b1;
            st_next = last_reg ? S_WAIT_DONE : S_GET;
          end else if (p_reg.mode_select == FCDP_MODE_SYNC_PERIPH && first_reg &&
                       bit_reg == 4'(FCDP_SYNC_FIRST_EDGE - 1)) begin
            // first byte taken on second edge after init rises
            first_next = 1'b0;
            bit_next = 4'h0;
            ready_next = 1'b1;
            st_next = last_reg ? S_FLUSH : S_GET;
          end else if (bit_reg == 4'(FCDP_BYTE_BITS - 1) && !first_reg) begin
            ready_next = 1'b1;
            st_next = last_reg ? S_FLUSH : S_GET;
          end else if (bit_reg == 4'(FCDP_BYTE_BITS - 1)) begin
            first_next = 1'b0;
            ready_next = 1'b1;
            st_next = last_reg ? S_FLUSH : S_GET;
          end else begin
            st_next = S_CLK_LO;
          end
        end
      end
      S_FLUSH: begin
        // extra clocks let the device finish shifting the final byte
        p_next.bus_oe = 8'h00;
        cnt_next = 16'h0000;
        bit_next = 4'h0;
        if (done_s || bit_reg == 4'hF) begin
          st_next = S_WAIT_DONE;
        end else begin
          sh_next = 8'hFF;
          last_next = 1'b1;
          cnt_next = 16'h0001;
          st_next = S_CLK_LO;
        end
      end
      S_WAIT_DONE: begin
        if (done_s) begin
          // slave parallel stays selected until the device reports completion
          p_next.bus_oe = 8'h00;
          p_next.write_strobe_n = 1'b1;
          p_next.select_low = 1'b1;
          p_next.select_high = 1'b0;
          done_next = 1'b1;
          st_next = S_IDLE;
        end else if (!init_s) begin
          err_next = 1'b1;
          st_next = S_IDLE;
        end else if (is_ser || is_par_clk) begin
          // slave modes need the host to keep clocking until completion
          sh_next = 8'hFF;
          bit_next = 4'h0;
          last_next = 1'b1;
          cnt_next = 16'h0001;
          st_next = S_CLK_LO;
        end
      end
      default: st_next = S_IDLE;
    endcase
    if (st_reg != S_IDLE && st_reg != S_PULSE && st_reg != S_WAIT_INIT &&
        p_reg.mode_select == FCDP_MODE_ASYNC_PERIPH && !p_reg.read_strobe_n) begin
      p_next.read_strobe_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= S_IDLE;
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      last_reg <= 1'b0;
      first_reg <= 1'b0;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      p_reg <= '{program_request_n: 1'b1, config_clock: 1'b0, config_clock_oe: 1'b0,
                 select_low: 1'b1, select_high: 1'b0, write_strobe_n: 1'b1,
                 read_strobe_n: 1'b1, bus_out: 8'h00, bus_oe: 8'h00, serial_out: 1'b1,
                 mode_select: FCDP_MODE_MASTER_SERIAL, osc_rate_select: FCDP_OSC_SLOW};
    end else if (ce) begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      last_reg <= last_next;
      first_reg <= first_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      err_reg <= err_next;
      p_reg <= p_next;
    end
  end

  logic busy_reg;
  logic busy_next;
  assign busy_next = (st_next != S_IDLE);
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else if (ce) begin
      busy_reg <= busy_next;
    end
  end

  // unused status sample kept for later async polling via D7
  logic d7_unused;
  assign d7_unused = d7_s;
  assign byte_ready = ready_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign error = err_reg;
  assign pins = p_reg;
endmodule
`default_nettype wire

/* bench/fcdp_host_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module fcdp_host_sva import fcdp_pkg::*; #(
  parameter int HALF = FCDP_HALF_PERIOD_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic byte_ready,
  input wire logic busy,
  input wire logic done,
  input wire logic error,
  input wire fcdp_pins_t pins,
  input wire logic byte_accept
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] low_cnt_reg;
  logic [7:0] hold_cnt_reg;
  logic sel;
  assign sel = !pins.select_low && pins.select_high;
  // hold_cnt_reg saturates so a long idle clock never wraps into a false period; low_cnt_reg does not saturate
  always_ff @(posedge clk) begin
    if (rst || pins.program_request_n) low_cnt_reg <= 8'h00;
    else low_cnt_reg <= low_cnt_reg + 8'h01;
    if (rst || $changed(pins.config_clock)) hold_cnt_reg <= 8'h00;
    else if (hold_cnt_reg != 8'hFF) hold_cnt_reg <= hold_cnt_reg + 8'h01;
  end
  sequence s_wr_low4;
    !pins.write_strobe_n [*4] ##1 pins.write_strobe_n;
  endsequence
  a_prog_width: assert property (
    $rose(pins.program_request_n) |-> low_cnt_reg == 8'(FCDP_PROGRAM_REQUEST_N_CYCLES))
    else $error("program pulse width wrong");
  a_osc_slow: assert property (pins.osc_rate_select == FCDP_OSC_SLOW)
    else $error("oscillator select not slow");
  a_wr_selected: assert property (
    !pins.write_strobe_n |-> sel && pins.bus_oe == 8'hFF)
    else $error("write without selects or bus");
  a_wr_width: assert property (
    $fell(pins.write_strobe_n) && pins.mode_select == FCDP_MODE_ASYNC_PERIPH |-> s_wr_low4)
    else $error("write strobe width wrong");
  a_wr_waits_ready: assert property (
    $fell(pins.write_strobe_n) && pins.mode_select == FCDP_MODE_ASYNC_PERIPH
    |-> $past(byte_accept, 2)) else $error("write while device busy");
  a_wr_gap: assert property (
    $rose(pins.write_strobe_n) && pins.mode_select == FCDP_MODE_ASYNC_PERIPH
    |-> pins.write_strobe_n [*4]) else $error("write gap too short");
  a_par_held: assert property (
    $fell(sel) && pins.mode_select == FCDP_MODE_SLAVE_PARALLEL |-> done)
    else $error("slave parallel deselected early");
  a_clk_period: assert property (
    $changed(pins.config_clock) && hold_cnt_reg < 8'(2 * HALF)
    |-> hold_cnt_reg == 8'(HALF - 1)) else $error("config clock half period wrong");
  a_data_stable: assert property (
    $rose(pins.config_clock) |-> $stable(pins.serial_out) && $stable(pins.bus_out))
    else $error("data moved at clock rise");
  a_ready_pulse: assert property (byte_ready |=> !byte_ready)
    else $error("byte ready longer than one cycle");
  a_err_ends: assert property ($rose(error) |-> ##[0:2] !busy)
    else $error("load continues after error");
endmodule
bind fcdp_host fcdp_host_sva #(.HALF(HALF)) u_sva (.clk(clk), .rst(rst),
  .byte_ready(byte_ready), .busy(busy), .done(done), .error(error), .pins(pins),
  .byte_accept(byte_accept));
`default_nettype wire

/* bench/fcdp_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fcdp_dev_model import fcdp_pkg::*; #(
  parameter int NB = 3,
  parameter int MS_SLOW = 300,
  parameter int MS_FAST = 60
) (
  input wire logic clk,
  input wire logic rst,
  input wire fcdp_pins_t pins,
  input wire logic inject_err,
  output logic init_status_n,
  output logic config_complete,
  output logic byte_accept,
  output logic [7:0] bus_in
);
  logic [7:0] rx [0:7];
  logic [7:0] sh_reg;
  logic [7:0] noise_reg;
  logic [2:0] md_reg;
  logic cc_d, wr_d, err_reg, took_reg, rise, fall_wr, sel, status_d7;
  int nbits, nbytes, edges, wait_cnt, busy_cnt;
  assign sel = !pins.select_low && pins.select_high;
  assign rise = pins.config_clock && !cc_d;
  assign fall_wr = wr_d && !pins.write_strobe_n;
  assign status_d7 = (!pins.read_strobe_n && sel && pins.write_strobe_n) ? byte_accept
                     : noise_reg[7];
  // undriven lines show a moving pattern, not the last value
  assign bus_in = (pins.bus_oe & pins.bus_out) | (~pins.bus_oe & {status_d7, noise_reg[6:0]});
  always_ff @(posedge clk) begin
    cc_d <= pins.config_clock;
    wr_d <= pins.write_strobe_n;
    noise_reg <= rst ? 8'h00 : noise_reg + 8'h5B;
    if (rst || !pins.program_request_n) begin
      init_status_n <= 1'b0;
      config_complete <= 1'b0;
      byte_accept <= 1'b1;
      err_reg <= 1'b0;
      took_reg <= 1'b0;
      md_reg <= pins.mode_select;
      nbits <= 0;
      nbytes <= 0;
      edges <= 0;
      busy_cnt <= 0;
      wait_cnt <= 8;
    end else if (inject_err || err_reg) begin
      err_reg <= 1'b1;
      init_status_n <= 1'b0;
    end else if (wait_cnt != 0) begin
      wait_cnt <= wait_cnt - 1;
      init_status_n <= (wait_cnt == 1);
    end else if (nbytes >= NB) begin
      config_complete <= 1'b1;
      byte_accept <= 1'b1;
    end else if (md_reg == FCDP_MODE_MASTER_SERIAL) begin
      // own oscillator paces the load; nothing crosses the host port
      edges <= edges + 1;
      if (edges >= (pins.osc_rate_select ? MS_SLOW : MS_FAST)) nbytes <= NB;
    end else begin
      if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
      if (md_reg == FCDP_MODE_ASYNC_PERIPH) begin
        byte_accept <= (busy_cnt <= 1);
        if (fall_wr && sel) begin
          rx[nbytes] <= pins.bus_out;
          nbytes <= nbytes + 1;
          busy_cnt <= 16;
          byte_accept <= 1'b0;
        end
      end
      if (rise) begin
        edges <= edges + 1;
        case (md_reg)
          FCDP_MODE_SLAVE_SERIAL: begin
            sh_reg <= {pins.serial_out, sh_reg[7:1]};
            nbits <= nbits + 1;
            if (nbits % 8 == 7) begin
              rx[nbytes] <= {pins.serial_out, sh_reg[7:1]};
              nbytes <= nbytes + 1;
            end
          end
          FCDP_MODE_SLAVE_PARALLEL: begin
            if (sel && !pins.write_strobe_n) begin
              rx[nbytes] <= pins.bus_out;
              nbytes <= nbytes + 1;
            end
          end
          FCDP_MODE_SYNC_PERIPH: begin
            took_reg <= (edges % 8 == 1);
            byte_accept <= took_reg;
            if (edges % 8 == 1) begin
              rx[nbytes] <= pins.bus_out;
              nbytes <= nbytes + 1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* bench/test_fcdp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module test_fcdp_host import fcdp_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [2:0] mode = 3'h0;
  logic program_req = 1'b0;
  fcdp_byte_t byte_in = '0;
  logic last_byte = 1'b0;
  logic inject_err = 1'b0;
  logic byte_ready, busy, done, error, init_status_n, config_complete, byte_accept;
  logic [7:0] bus_in;
  fcdp_pins_t pins;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam logic [7:0] PAT [0:2] = '{8'hA5, 8'h3C, 8'h81};
  always #5 clk = ~clk;
  fcdp_host #(.HALF(4)) uut (.clk(clk), .rst(rst), .ce(ce), .mode(mode),
    .program_req(program_req), .byte_in(byte_in), .byte_ready(byte_ready),
    .last_byte(last_byte), .busy(busy), .done(done), .error(error), .pins(pins),
    .init_status_n(init_status_n), .config_complete(config_complete),
    .byte_accept(byte_accept), .bus_in(bus_in));
  fcdp_dev_model #(.NB(3)) partner (.clk(clk), .rst(rst), .pins(pins),
    .inject_err(inject_err), .init_status_n(init_status_n),
    .config_complete(config_complete), .byte_accept(byte_accept), .bus_in(bus_in));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic start(input logic [2:0] m);
    tick();
    mode = m;
    program_req = 1'b1;
    tick();
    program_req = 1'b0;
  endtask
  // next byte is offered in the cycle of byte_ready, never earlier
  task automatic load(input logic [2:0] m, input int n, input logic [7:0] x);
    int k;
    start(m);
    for (int i = 0; i < n; i++) begin
      byte_in = {1'b1, PAT[i] ^ x};
      last_byte = (i == n - 1);
      k = 0;
      do begin
        tick();
        k++;
      end while (byte_ready !== 1'b1 && k < 3000);
      chk("byte_ready", {7'h00, byte_ready}, 8'h01);
    end
    byte_in = '0;
    last_byte = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 5000) begin
      tick();
      k++;
    end
    chk("done", {7'h00, done}, 8'h01);
    chk("error", {7'h00, error}, 8'h00);
  endtask
  task automatic chk_rx(input logic [7:0] x);
    for (int i = 0; i < 3; i++) chk("received byte", partner.rx[i], PAT[i] ^ x);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("program_request_n", {7'h00, pins.program_request_n}, 8'h01);
    chk("write_strobe_n", {7'h00, pins.write_strobe_n}, 8'h01);
    chk("bus_oe", pins.bus_oe, 8'h00);
    chk("osc_rate_select", {7'h00, pins.osc_rate_select}, 8'h01);
    chk("busy", {7'h00, busy}, 8'h00);
  endtask
  task automatic t_master();
    load(FCDP_MODE_MASTER_SERIAL, 0, 8'h00);
  endtask
  task automatic t_error();
    int k;
    start(FCDP_MODE_SLAVE_SERIAL);
    byte_in = {1'b1, PAT[0]};
    repeat (100) tick();
    inject_err = 1'b1;
    tick();
    inject_err = 1'b0;
    k = 0;
    while (error !== 1'b1 && k < 100) begin
      tick();
      k++;
    end
    byte_in = '0;
    repeat (20) tick();
    chk("error", {7'h00, error}, 8'h01);
    chk("busy", {7'h00, busy}, 8'h00);
    chk("init_status_n", {7'h00, init_status_n}, 8'h00);
  endtask
  task automatic t_serial();
    load(FCDP_MODE_SLAVE_SERIAL, 3, 8'h00);
    chk_rx(8'h00);
  endtask
  task automatic t_async();
    load(FCDP_MODE_ASYNC_PERIPH, 3, 8'h0F);
    chk_rx(8'h0F);
  endtask
  task automatic t_sync();
    load(FCDP_MODE_SYNC_PERIPH, 3, 8'hF0);
    chk_rx(8'hF0);
  endtask
  task automatic t_par();
    load(FCDP_MODE_SLAVE_PARALLEL, 3, 8'h66);
    chk_rx(8'h66);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_master();
    t_error();
    t_serial();
    t_async();
    t_sync();
    t_par();
    give_verdict();
  end
endmodule
`default_nettype wire
